// ### rtl/ies_pkg.sv
package ies_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int AW = 12;
   localparam logic [11:0] OFS_FLAG = 12'h000;
   localparam logic [11:0] OFS_ISP = 12'h004;
   localparam logic [11:0] OFS_USP = 12'h008;
   localparam logic [11:0] OFS_VBASE = 12'h00c;
   localparam logic [11:0] OFS_STAT = 12'h010;
   localparam logic [11:0] OFS_MASK = 12'h014;
   localparam logic [11:0] OFS_STATE = 12'h018;
   localparam logic [11:0] OFS_SRC = 12'h040;

   // ------------------------------------------------------------
   // Flag word and source control layout
   // ------------------------------------------------------------
   localparam int FW = 16;
   localparam int FLG_D = 1;
   localparam int FLG_I = 6;
   localparam int FLG_U = 7;
   localparam int IPL_LSB = 12;
   localparam int LVL_W = 3;
   localparam int CTL_REQ = 3;
   localparam logic [15:0] FLG_RST = 16'h0000;
   localparam logic [15:0] SP_RST = 16'h0000;
   localparam logic [15:0] SP_STEP = 16'h0002;

   // ------------------------------------------------------------
   // Interrupt number space
   // ------------------------------------------------------------
   localparam int NUM_W = 6;
   localparam logic [5:0] PERIPH_LO = 6'h0b;
   localparam logic [5:0] PERIPH_HI = 6'h1f;
   localparam logic [5:0] U_KEEP_LO = 6'h20;

   // ------------------------------------------------------------
   // Event status bits
   // ------------------------------------------------------------
   localparam int EV_ENTRY = 0;
   localparam int EV_RET = 1;
   localparam int EV_W = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SAVE = 3'h1,
      ST_PSHF = 3'h3,
      ST_PSHP = 3'h2,
      ST_VECT = 3'h6,
      ST_POPP = 3'h4,
      ST_POPF = 3'h5
   } ies_state_e;

endpackage

// ### rtl/ies_arbiter.sv
`timescale 1ns/1ps
module ies_arbiter
   import ies_pkg::*;
#(
   parameter int N = 21
) (
   // Per-source level and pending flag
   input wire logic [N-1:0][LVL_W-1:0] lvl,
   input wire logic [N-1:0] req,
   // Winner
   output logic valid,
   output logic [$clog2(N)-1:0] idx,
   output logic [LVL_W-1:0] best
);

   localparam int IW = $clog2(N);

   if (N < 2) begin : g_chk
      $error("ies_arbiter needs at least two sources");
   end

   logic [LVL_W-1:0] bl [N+1];
   logic [IW-1:0] bi [N+1];

   assign bl[0] = '0;
   assign bi[0] = '0;

   // Strict compare: a later source only wins with a higher level,
   // so on a tie the lower index keeps it
   for (genvar k = 0; k < N; k++) begin : g_chain
      wire win = req[k] & (lvl[k] > bl[k]);
      assign bl[k+1] = win ? lvl[k] : bl[k];
      assign bi[k+1] = win ? IW'(k) : bi[k];
   end

   assign best = bl[N];
   assign idx = bi[N];
   assign valid = |bl[N];

endmodule

// ### rtl/ies_sequencer.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ies_sequencer
   import ies_pkg::*;
#(
   parameter int NUM_SRC = 21
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral request set strobes
   input wire logic [NUM_SRC-1:0] src_set,
   // CPU core side
   input wire logic cpu_boundary,
   input wire logic sw_req,
   input wire logic [NUM_W-1:0] sw_num,
   input wire logic ret_req,
   input wire logic [FW-1:0] cpu_pc,
   output logic busy,
   output logic entry_done,
   output logic ret_done,
   output logic [FW-1:0] pc_load,
   // Stack and vector memory
   output logic mem_req,
   output logic mem_we,
   output logic [FW-1:0] mem_addr,
   output logic [FW-1:0] mem_wdata,
   input wire logic [FW-1:0] mem_rdata,
   input wire logic mem_ack,
   // Interrupt to host
   output logic irq
);

   localparam int SIW = $clog2(NUM_SRC);
   localparam int MAX_SRC = int'(PERIPH_HI) - int'(PERIPH_LO) + 1;

   if (NUM_SRC < 2 || NUM_SRC > MAX_SRC) begin : g_chk
      $error("NUM_SRC must fit the peripheral number range");
   end

   // Layout comes from the package; a field pushed outside its
   // word would silently vanish from the saved frame
   if (FLG_U >= FW || FLG_I >= FW || FLG_D >= FW ||
       IPL_LSB + LVL_W > FW) begin : g_flg_chk
      $error("flag fields must lie inside the flag word");
   end
   if (CTL_REQ < LVL_W || CTL_REQ > 31) begin : g_ctl_chk
      $error("request bit must sit above the level field");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   ies_state_e st_q, st_d;
   logic [FW-1:0] flg_q, flg_d;
   logic [FW-1:0] isp_q, isp_d;
   logic [FW-1:0] usp_q, usp_d;
   logic [FW-1:0] vbase_q;
   logic [FW-1:0] tmp_q;
   logic [FW-1:0] pc_q;
   logic [FW-1:0] pc_load_q;
   logic [NUM_W-1:0] num_q;
   logic hw_q;
   logic [SIW-1:0] src_q;
   logic [LVL_W-1:0] lvl_acc_q;
   logic entry_q;
   logic ret_q;
   logic [EV_W-1:0] stat_q;
   logic [EV_W-1:0] mask_q;
   logic [31:0] prdata_q;
   logic [NUM_SRC-1:0][LVL_W-1:0] lvl_q;
   logic [NUM_SRC-1:0] req_q;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire wr_en = psel & penable & pwrite;
   wire [AW-1:0] src_off = paddr - OFS_SRC;
   wire [AW-3:0] src_word = src_off[AW-1:2];
   wire [SIW-1:0] sidx = src_word[SIW-1:0];
   wire in_src = (paddr >= OFS_SRC) && (paddr[1:0] == 2'h0) &&
                 (src_word < (AW-2)'(NUM_SRC));
   wire hit_flag = paddr == OFS_FLAG;
   wire hit_isp = paddr == OFS_ISP;
   wire hit_usp = paddr == OFS_USP;
   wire hit_vbase = paddr == OFS_VBASE;
   wire hit_stat = paddr == OFS_STAT;
   wire hit_mask = paddr == OFS_MASK;
   wire hit_state = paddr == OFS_STATE;
   wire hit = hit_flag | hit_isp | hit_usp | hit_vbase | hit_stat |
              hit_mask | hit_state | in_src;
   wire setup_ph = psel & ~penable;
   wire wr_flag = wr_en & hit_flag;
   wire wr_isp = wr_en & hit_isp;
   wire wr_usp = wr_en & hit_usp;
   wire wr_vbase = wr_en & hit_vbase;
   wire wr_stat = wr_en & hit_stat;
   wire wr_mask = wr_en & hit_mask;
   wire wr_src = wr_en & in_src;

   wire [31:0] rd_mux =
      hit_flag ? {16'h0000, flg_q} :
      hit_isp ? {16'h0000, isp_q} :
      hit_usp ? {16'h0000, usp_q} :
      hit_vbase ? {16'h0000, vbase_q} :
      hit_stat ? {30'h0, stat_q} :
      hit_mask ? {30'h0, mask_q} :
      hit_state ? {28'h0, busy, st_q} :
      in_src ? {28'h0, req_q[sidx], lvl_q[sidx]} : 32'h0;

   // Read data is caught in the setup cycle, so the access cycle
   // always completes at once and prdata comes from a flip-flop
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign prdata = prdata_q;

   // ------------------------------------------------------------
   // Priority resolution
   // ------------------------------------------------------------
   logic arb_valid;
   logic [SIW-1:0] arb_idx;
   logic [LVL_W-1:0] arb_lvl;

   ies_arbiter #(
      .N(NUM_SRC)
   ) u_arb (
      .lvl(lvl_q),
      .req(req_q),
      .valid(arb_valid),
      .idx(arb_idx),
      .best(arb_lvl)
   );

   // ------------------------------------------------------------
   // State decode
   // ------------------------------------------------------------
   wire in_save = st_q == ST_SAVE;
   wire in_pshf = st_q == ST_PSHF;
   wire in_pshp = st_q == ST_PSHP;
   wire in_vect = st_q == ST_VECT;
   wire in_popp = st_q == ST_POPP;
   wire in_popf = st_q == ST_POPF;

   // ------------------------------------------------------------
   // Acceptance
   // ------------------------------------------------------------
   wire cur_u = flg_q[FLG_U];
   wire [FW-1:0] cur_sp = cur_u ? usp_q : isp_q;
   wire [FW-1:0] sp_dec = cur_sp - SP_STEP;
   wire [FW-1:0] sp_inc = cur_sp + SP_STEP;
   wire [LVL_W-1:0] current_priority_level = flg_q[IPL_LSB +: LVL_W];
   wire idle = st_q == ST_IDLE;
   // Requests at or below the current level just stay pending
   wire hw_ok = arb_valid & flg_q[FLG_I] & (arb_lvl > current_priority_level);
   wire start_ret = idle & ret_req;
   wire start_sw = idle & ~ret_req & sw_req;
   wire start_hw = idle & ~ret_req & ~sw_req & cpu_boundary & hw_ok;
   wire start = start_sw | start_hw;
   wire ack = mem_req & mem_ack;
   wire ev_entry = ack & in_vect;
   wire ev_ret = ack & in_popf;
   wire clr_req = ack & in_pshp & hw_q;
   wire sp_mv = ack & ~in_vect;
   wire pc_take = ack & (in_vect | in_popp);
   wire [FW-1:0] sp_new = mem_we ? sp_dec : sp_inc;
   wire [NUM_W-1:0] hw_num = PERIPH_LO + NUM_W'(arb_idx);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (start_ret) begin
               st_d = ST_POPP;
            end else if (start) begin
               st_d = ST_SAVE;
            end
         end
         ST_SAVE: st_d = ST_PSHF;
         ST_PSHF: if (ack) st_d = ST_PSHP;
         ST_PSHP: if (ack) st_d = ST_VECT;
         ST_VECT: if (ack) st_d = ST_IDLE;
         ST_POPP: if (ack) st_d = ST_POPF;
         ST_POPF: if (ack) st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // Sequencer wins over a software write in the same cycle
   always_comb begin
      flg_d = flg_q;
      if (in_save) begin
         flg_d[FLG_I] = 1'b0;
         flg_d[FLG_D] = 1'b0;
         if (num_q < U_KEEP_LO) begin
            flg_d[FLG_U] = 1'b0;
         end
      end else if (clr_req) begin
         flg_d[IPL_LSB +: LVL_W] = lvl_acc_q;
      end else if (ev_ret) begin
         flg_d = mem_rdata;
      end else if (wr_flag) begin
         flg_d = pwdata[FW-1:0];
      end
   end

   assign isp_d = (sp_mv && !cur_u) ? sp_new :
                  wr_isp ? pwdata[FW-1:0] : isp_q;
   assign usp_d = (sp_mv && cur_u) ? sp_new :
                  wr_usp ? pwdata[FW-1:0] : usp_q;

   // ------------------------------------------------------------
   // Memory port
   // ------------------------------------------------------------
   assign mem_req = in_pshf | in_pshp | in_vect | in_popp | in_popf;
   assign mem_we = in_pshf | in_pshp;
   // Pushes go below the pointer of the flags as modified
   assign mem_addr = in_vect ?
                     vbase_q + {9'h000, num_q, 1'b0} :
                     mem_we ? sp_dec : cur_sp;
   assign mem_wdata = in_pshf ? tmp_q : pc_q;

   assign busy = ~idle;
   assign entry_done = entry_q;
   assign ret_done = ret_q;
   assign pc_load = pc_load_q;
   assign irq = |(stat_q & mask_q);
   wire [EV_W-1:0] stat_clr = wr_stat ? pwdata[EV_W-1:0] : {EV_W{1'b0}};
   wire [EV_W-1:0] stat_set = {ev_ret, ev_entry};

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         flg_q <= FLG_RST;
         isp_q <= SP_RST;
         usp_q <= SP_RST;
      end else begin
         st_q <= st_d;
         flg_q <= flg_d;
         isp_q <= isp_d;
         usp_q <= usp_d;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tmp_q <= FLG_RST;
         pc_q <= '0;
         num_q <= '0;
         hw_q <= 1'b0;
         src_q <= '0;
         lvl_acc_q <= '0;
      end else if (start) begin
         tmp_q <= flg_q;
         pc_q <= cpu_pc;
         num_q <= start_sw ? sw_num : hw_num;
         hw_q <= start_hw;
         src_q <= arb_idx;
         lvl_acc_q <= arb_lvl;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pc_load_q <= '0;
         entry_q <= 1'b0;
         ret_q <= 1'b0;
      end else begin
         if (pc_take) begin
            pc_load_q <= mem_rdata;
         end
         entry_q <= ev_entry;
         ret_q <= ev_ret;
      end
   end

   // Event set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stat_q <= '0;
         mask_q <= '0;
         vbase_q <= '0;
         prdata_q <= '0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
         if (wr_mask) mask_q <= pwdata[EV_W-1:0];
         if (wr_vbase) vbase_q <= pwdata[FW-1:0];
         if (setup_ph) prdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Source control registers
   // ------------------------------------------------------------
   for (genvar k = 0; k < NUM_SRC; k++) begin : g_src
      wire sel = wr_src & (sidx == SIW'(k));
      wire clr = clr_req & (src_q == SIW'(k));
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            lvl_q[k] <= '0;
            req_q[k] <= 1'b0;
         end else begin
            if (sel) lvl_q[k] <= pwdata[LVL_W-1:0];
            if (src_set[k]) begin
               req_q[k] <= 1'b1;
            end else if (sel) begin
               req_q[k] <= pwdata[CTL_REQ];
            end else if (clr) begin
               req_q[k] <= 1'b0;
            end
         end
      end
   end

endmodule

// ### sim/ies_mem_model.sv
`timescale 1ns/1ps
module ies_mem_model
   import ies_pkg::*;
(
   // Clock and answer delay
   input wire logic clock,
   input wire logic [1:0] lag,
   // Stack and vector port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [FW-1:0] mem_addr,
   input wire logic [FW-1:0] mem_wdata,
   output logic [FW-1:0] mem_rdata,
   output logic mem_ack
);
   logic [FW-1:0] ram [0:32767];
   logic [FW-1:0] last_q = 16'h5a5a;
   logic [1:0] wait_q = 2'h0;
   assign mem_ack = mem_req && wait_q == lag;
   // Off-answer lines show the inverse, so a stale word never passes
   assign mem_rdata = mem_ack ? ram[mem_addr[15:1]] : ~last_q;
   always @(posedge clock) begin
      wait_q <= mem_ack ? 2'h0 : wait_q + {1'b0, mem_req};
      if (mem_ack) begin
         last_q <= mem_we ? mem_wdata : mem_rdata;
      end
      if (mem_ack && mem_we) begin
         ram[mem_addr[15:1]] <= mem_wdata;
      end
   end
endmodule

// ### sim/ies_sequencer_monitor.sv
`timescale 1ns/1ps
module ies_sequencer_monitor
   import ies_pkg::*;
#(
   parameter int NUM_SRC = 21
) (
   // Clock, reset and bus
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [AW-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Core and memory side
   input wire logic ret_req,
   input wire logic busy,
   input wire logic entry_done,
   input wire logic ret_done,
   input wire logic [FW-1:0] pc_load,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [FW-1:0] mem_addr,
   input wire logic [FW-1:0] mem_rdata,
   input wire logic mem_ack
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_align: assert property (
      psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   a_push_first: assert property (
      $rose(busy) && !$past(ret_req) |->
      !mem_req ##1 (mem_req && mem_we))
      else $error("entry does not save then push");
   a_sp_step: assert property (
      (mem_req && mem_we && mem_ack) ##1 (mem_req && mem_we) |->
      mem_addr == $past(mem_addr) - 16'h0002)
      else $error("second push not two below first");
   a_req_hold: assert property (
      mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped or changed");
   a_vec_load: assert property (
      entry_done |->
      $past(mem_ack && !mem_we) && pc_load == $past(mem_rdata))
      else $error("handler address not from vector read");
   a_busy_hold: assert property (
      busy |=> busy || entry_done || ret_done)
      else $error("sequence broken off");
   a_busy_bound: assert property (
      $rose(busy) |-> ##[2:40] (entry_done || ret_done))
      else $error("sequence too long");
   a_done_pulse: assert property (
      entry_done || ret_done |=> !entry_done && !ret_done)
      else $error("done longer than one cycle");
   c_entry: cover property (entry_done);
   c_return: cover property (ret_done);
   c_refused: cover property (psel && penable && pslverr);
endmodule

bind ies_sequencer ies_sequencer_monitor #(.NUM_SRC(NUM_SRC)) mon_u (
   .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .ret_req(ret_req),
   .busy(busy), .entry_done(entry_done), .ret_done(ret_done),
   .pc_load(pc_load), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
);

// ### sim/interrupt_entry_sequencer_tb.sv
`timescale 1ns/1ps
module interrupt_entry_sequencer_tb;
   import ies_pkg::*;
   logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er, u;
   logic pready, pslverr, busy, entry_done, ret_done, irq, mem_req, mem_we;
   logic mem_ack, cpu_boundary = 1, sw_req = 0, ret_req = 0;
   logic [AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [20:0] src_set = '0;
   logic [NUM_W-1:0] sw_num = '0;
   logic [FW-1:0] cpu_pc = '0, pc_load, mem_addr, mem_wdata, mem_rdata;
   logic [1:0] lag = '0;
   int err_count = 0, total_checks = 0, cyc = 0, seed = 32'h94e0;
   int m_flag = 0, m_isp = 0, m_usp = 0, n, sp, f, pc;
   int stk[$];
   initial begin
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         complete_run;
      end
   end
   ies_sequencer #(.NUM_SRC(21)) dut (.clock, .nrst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_set,
      .cpu_boundary, .sw_req, .sw_num, .ret_req, .cpu_pc, .busy,
      .entry_done, .ret_done, .pc_load, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack, .irq);
   ies_mem_model mem_u (.clock, .lag, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task regs;
      apb(0, OFS_FLAG, 0);
      chk(rd, m_flag);
      apb(0, OFS_ISP, 0);
      chk(rd, m_isp);
      apb(0, OFS_USP, 0);
      chk(rd, m_usp);
   endtask
   task wait_done(input logic r);
      n = 0;
      do @(posedge clock);
      while ((r ? ret_done : entry_done) !== 1'b1 && ++n < 100);
      chk(n < 100, 1);
   endtask
   task entry(input int num, input int lvl);
      f = m_flag;
      pc = cpu_pc;
      m_flag = f & ~32'h42 & ~(num < 32 ? 32'h80 : 0);
      if (lvl > 0) m_flag = m_flag & ~32'h7000 | lvl << 12;
      wait_done(0);
      sp = (m_flag[7] ? m_usp : m_isp) - 4;
      if (m_flag[7]) m_usp = sp;
      else m_isp = sp;
      chk(pc_load, mem_u.ram[1024 + num]);
      chk(mem_u.ram[(sp + 2) >> 1], f);
      chk(mem_u.ram[sp >> 1], pc);
      stk.push_back(f);
      stk.push_back(pc);
      regs;
   endtask
   task ret(input logic rg);
      u = m_flag[7];
      sp = u ? m_usp : m_isp;
      @(posedge clock);
      ret_req <= 1;
      @(posedge clock);
      ret_req <= 0;
      wait_done(1);
      chk(pc_load, stk.pop_back());
      m_flag = stk.pop_back();
      if (u) m_usp = sp + 4;
      else m_isp = sp + 4;
      if (rg) regs;
   endtask
   task trig(input int num, input logic [20:0] s);
      @(posedge clock);
      sw_req <= s == 0;
      sw_num <= num[5:0];
      src_set <= s;
      cpu_pc <= 16'($random(seed)) & 16'hfffe;
      lag <= s == 0 ? 2'($random(seed)) : 2'h3;
      @(posedge clock);
      sw_req <= 0;
      src_set <= '0;
   endtask
   task complete_run;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      for (int k = 0; k < 64; k++) mem_u.ram[1024 + k] = 16'h8000 + 4 * k;
      repeat (20) @(posedge clock);
      nrst <= 1;
      regs;
      apb(0, 12'h020, 0);
      chk(er, 1);
      chk(rd, 0);
      apb(0, 12'h002, 0);
      chk(er, 1);
      apb(1, OFS_ISP, 32'h4000);
      apb(1, OFS_USP, 32'h6000);
      apb(1, OFS_VBASE, 32'h0800);
      apb(1, OFS_FLAG, 32'h00c2);
      m_isp = 32'h4000;
      m_usp = 32'h6000;
      m_flag = 32'hc2;
      trig(5, 0);
      entry(5, 0);
      chk(irq, 0);
      apb(1, OFS_MASK, 3);
      apb(0, OFS_STAT, 0);
      chk(irq, 1);
      chk(rd, 1);
      apb(1, OFS_STAT, 1);
      apb(0, OFS_STAT, 0);
      chk(irq, 0);
      chk(rd, 0);
      ret(1);
      trig(40, 0);
      entry(40, 0);
      ret(1);
      apb(1, OFS_SRC, 3);
      apb(1, OFS_SRC + 8, 3);
      apb(1, OFS_SRC + 16, 0);
      trig(11, 21'h15);
      entry(11, 3);
      repeat (10) @(posedge clock);
      chk(busy, 0);
      apb(0, OFS_SRC, 0);
      chk(rd, 3);
      apb(0, OFS_SRC + 8, 0);
      chk(rd, 32'hb);
      apb(1, OFS_FLAG, m_flag | 32'h40);
      m_flag = m_flag | 32'h40;
      apb(1, OFS_SRC + 4, 5);
      chk(busy, 0);
      cpu_boundary <= 0;
      trig(12, 21'h2);
      repeat (3) @(posedge clock);
      chk(busy, 0);
      cpu_boundary <= 1;
      entry(12, 5);
      ret(1);
      chk(busy, 0);
      ret(0);
      entry(13, 3);
      ret(1);
      apb(0, OFS_SRC + 16, 0);
      chk(busy, 0);
      chk(rd, 8);
      complete_run;
   end
endmodule
